/* verilog/esr_consts.svh */
`ifndef ESR_CONSTS_SVH
`define ESR_CONSTS_SVH

// Clock rate and documented times
`define ESR_CLK_MHZ 250
`define ESR_STEP_FULL_US 1000
`define ESR_STEP_FRAC_US 320
`define ESR_SC_TIME_US 1000
`define ESR_ILIM_TIME_US 20

// Register byte offsets
`define ESR_ADDR_CTRL 8'h00
`define ESR_ADDR_DELAY 8'h01
`define ESR_ADDR_CONFIG 8'h02
`define ESR_ADDR_RESET 8'h03
`define ESR_ADDR_TOP_FLAGS 8'h04
`define ESR_ADDR_REG_FLAGS 8'h05
`define ESR_ADDR_TOP_MASK 8'h06
`define ESR_ADDR_REG_MASK 8'h07
`define ESR_ADDR_STATUS 8'h08
`define ESR_ADDR_PIN_IN 8'h09

// Control register fields
`define ESR_CTRL_EN 0
`define ESR_CTRL_PIN 1
`define ESR_CTRL_CHOICE_LSB 2
`define ESR_CTRL_CHOICE_MSB 3
`define ESR_DELAY_ON_LSB 0
`define ESR_DELAY_ON_MSB 3
`define ESR_DELAY_OFF_LSB 4
`define ESR_DELAY_OFF_MSB 7
`define ESR_CFG_DOUBLE 0
`define ESR_CFG_FRAC 1
`define ESR_RESET_TRIG 0

// Top flag positions
`define ESR_TF_TWARN 0
`define ESR_TF_TSD 1
`define ESR_TF_OVP 2
`define ESR_TF_PIN 3
`define ESR_TF_CLK 4
`define ESR_TF_MEAS 5
`define ESR_TF_RESTART 6
// Regulator flag positions
`define ESR_RF_ILIM 0
`define ESR_RF_SC 1
`define ESR_RF_PG 2

// Which flags a mask bit can silence
`define ESR_TOP_MASKABLE 7'h79
`define ESR_REG_MASKABLE 3'h5

// Reset values
`define ESR_CTRL_RST 8'h00
`define ESR_DELAY_RST 8'h00
`define ESR_CONFIG_RST 8'h00
`define ESR_MASK_RST 8'h00
`define ESR_BYTE_ZERO 8'h00

`endif

/* verilog/esr_pkg.sv */
package esr_pkg;
  // Reset and load sequencing
  typedef enum logic [1:0] {
    SEQ_HOLD = 2'b00,
    SEQ_SOFT = 2'b01,
    SEQ_LOAD = 2'b10,
    SEQ_RUN = 2'b11
  } esr_seq_t;
  typedef logic [7:0] esr_byte_t;
endpackage

/* verilog/esr_timer_if.sv */
`timescale 1ns/1ps
interface esr_timer_if;
  logic start;
  logic cancel;
  logic [3:0] code;
  logic dbl;
  logic frac;
  logic done;
  modport ctrl (output start, output cancel, output code, output dbl, output frac, input done);
  modport timer (input start, input cancel, input code, input dbl, input frac, output done);
endinterface

/* verilog/esr_delay_timer.sv */
`timescale 1ns/1ps
`include "esr_consts.svh"
module esr_delay_timer
  import esr_pkg::*;
#(
  parameter logic [19:0] FULL_CYC = 20'(`ESR_STEP_FULL_US * `ESR_CLK_MHZ),
  parameter logic [19:0] FRAC_CYC = 20'(`ESR_STEP_FRAC_US * `ESR_CLK_MHZ)
) (
  input wire logic clk,
  input wire logic rst,
  esr_timer_if.timer tif
);
  logic [19:0] pre_reg;
  logic [19:0] step_len_reg;
  logic [4:0] units_reg;
  logic active_reg;
  logic done_reg;

  // A doubled step is two plain steps, so only the unit count changes
  wire [4:0] load_units = tif.dbl ? {tif.code, 1'b0} : {1'b0, tif.code};
  wire [19:0] step_sel = tif.frac ? FRAC_CYC : FULL_CYC;
  wire step_end = (pre_reg == step_len_reg - 20'h0_0001);

  assign tif.done = done_reg;

  // A new start restarts timing, dropping any pending action
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_reg <= 20'h0_0000;
      step_len_reg <= 20'h0_0000;
      units_reg <= 5'h00;
      active_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (tif.start) begin
        pre_reg <= 20'h0_0000;
        step_len_reg <= step_sel;
        units_reg <= load_units;
        active_reg <= (load_units != 5'h00);
        done_reg <= (load_units == 5'h00);
      end else if (tif.cancel) begin
        active_reg <= 1'b0;
      end else if (active_reg) begin
        if (step_end) begin
          pre_reg <= 20'h0_0000;
          units_reg <= units_reg - 5'h01;
          if (units_reg == 5'h01) begin
            active_reg <= 1'b0;
            done_reg <= 1'b1;
          end
        end else begin
          pre_reg <= pre_reg + 20'h0_0001;
        end
      end
    end
  end
endmodule

/* verilog/esr_top.sv */
`timescale 1ns/1ps
`include "esr_consts.svh"
module esr_top
  import esr_pkg::*;
#(
  parameter logic [19:0] STEP_FULL_CYC = 20'(`ESR_STEP_FULL_US * `ESR_CLK_MHZ),
  parameter logic [19:0] STEP_FRAC_CYC = 20'(`ESR_STEP_FRAC_US * `ESR_CLK_MHZ),
  parameter logic [19:0] SC_CYC = 20'(`ESR_SC_TIME_US * `ESR_CLK_MHZ),
  parameter logic [19:0] ILIM_CYC = 20'(`ESR_ILIM_TIME_US * `ESR_CLK_MHZ)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic analog_supply_ok,
  input wire logic external_reset_input_n,
  input wire logic [7:0] fuse_ctrl,
  input wire logic [7:0] fuse_delay,
  input wire logic [7:0] fuse_config,
  input wire logic [2:0] enable_inputs,
  input wire logic vout_above_sc,
  input wire logic current_limit_active,
  input wire logic thermal_warning_in,
  input wire logic thermal_shutdown_in,
  input wire logic overvoltage_in,
  input wire logic power_good_in,
  input wire logic [3:0] gpio_in,
  input wire logic ext_clk_present,
  input wire logic meas_done,
  output logic main_regulator,
  output logic gpio_force_low,
  output logic interrupt_output_low_n
);
  // Clear is held off by a live condition; a new event always wins
  function automatic logic esr_flag(input logic flag, input logic set, input logic clr,
                                    input logic hold);
    esr_flag = set | (flag & ~(clr & ~hold));
  endfunction

  function automatic logic esr_rise(input logic cur, input logic prev);
    esr_rise = cur & ~prev;
  endfunction

  esr_seq_t seq_reg;
  esr_seq_t seq_next;
  esr_byte_t ctrl_reg;
  esr_byte_t delay_reg;
  esr_byte_t config_reg;
  esr_byte_t top_mask_reg;
  esr_byte_t reg_mask_reg;
  esr_byte_t rdata_reg;
  logic [6:0] top_flags_reg;
  logic [6:0] top_flags_next;
  logic [2:0] reg_flags_reg;
  logic [2:0] reg_flags_next;
  logic main_regulator_reg;
  logic main_regulator_next;
  logic gpio_force_low_reg;
  logic irq_n_reg;
  logic pin_prev_reg;
  logic target_on_reg;
  logic fault_pending_reg;
  logic [19:0] sc_cnt_reg;
  logic [19:0] ilim_cnt_reg;
  logic ilim_state_reg;
  logic tw_prev_reg;
  logic ts_prev_reg;
  logic ov_prev_reg;
  logic pg_prev_reg;
  logic clk_prev_reg;
  logic reg_on_prev_reg;
  logic [3:0] gpio_prev_reg;

  esr_timer_if tif();

  esr_delay_timer #(
    .FULL_CYC(STEP_FULL_CYC),
    .FRAC_CYC(STEP_FRAC_CYC)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .tif(tif)
  );

  // Lockout or reset pin low holds registers, flags and regulator in defaults
  wire in_hold = ~analog_supply_ok | ~external_reset_input_n;
  wire running = (seq_reg == SEQ_RUN) & ~in_hold;
  wire clr_regs = in_hold | (seq_reg == SEQ_HOLD) | (seq_reg == SEQ_SOFT);
  wire load_fuse = (seq_reg == SEQ_LOAD) & ~in_hold;

  // Bus decode; writes are ignored until the load has finished
  wire wr_ok = wr & running;
  wire wr_ctrl = wr_ok & (addr == `ESR_ADDR_CTRL);
  wire wr_delay = wr_ok & (addr == `ESR_ADDR_DELAY);
  wire wr_config = wr_ok & (addr == `ESR_ADDR_CONFIG);
  wire wr_top_mask = wr_ok & (addr == `ESR_ADDR_TOP_MASK);
  wire wr_reg_mask = wr_ok & (addr == `ESR_ADDR_REG_MASK);
  wire [6:0] top_clr = (wr_ok & (addr == `ESR_ADDR_TOP_FLAGS)) ? wdata[6:0] : 7'h00;
  wire [2:0] reg_clr = (wr_ok & (addr == `ESR_ADDR_REG_FLAGS)) ? wdata[2:0] : 3'h0;
  // Trigger is never stored, so it reads back as zero with no clearing step
  wire soft_wr = wr_ok & (addr == `ESR_ADDR_RESET) & wdata[`ESR_RESET_TRIG];

  // Control field views
  wire en_bit = ctrl_reg[`ESR_CTRL_EN];
  wire pin_sel = ctrl_reg[`ESR_CTRL_PIN];
  wire [1:0] pin_choice = ctrl_reg[`ESR_CTRL_CHOICE_MSB:`ESR_CTRL_CHOICE_LSB];
  wire pin_mode = en_bit & pin_sel;

  // Choice 3 selects no pin and reads as a low input
  wire sel_pin = (pin_choice == 2'h0) ? enable_inputs[0] :
                 (pin_choice == 2'h1) ? enable_inputs[1] :
                 (pin_choice == 2'h2) ? enable_inputs[2] : 1'b0;
  wire pin_rise = pin_mode & esr_rise(sel_pin, pin_prev_reg);
  wire pin_fall = pin_mode & esr_rise(pin_prev_reg, sel_pin);

  // Delay timer hookup; leaving pin control drops any pending action
  assign tif.start = pin_rise | pin_fall;
  assign tif.cancel = ~pin_mode;
  assign tif.code = pin_rise ? delay_reg[`ESR_DELAY_ON_MSB:`ESR_DELAY_ON_LSB] :
                    delay_reg[`ESR_DELAY_OFF_MSB:`ESR_DELAY_OFF_LSB];
  assign tif.dbl = config_reg[`ESR_CFG_DOUBLE];
  assign tif.frac = config_reg[`ESR_CFG_FRAC];

  // Fault detection
  wire ts_rise = esr_rise(thermal_shutdown_in, ts_prev_reg);
  wire ov_rise = esr_rise(overvoltage_in, ov_prev_reg);
  wire sc_trip = main_regulator_reg & ~vout_above_sc &
                 (sc_cnt_reg == SC_CYC - 20'h0_0001);
  wire ilim_hit = current_limit_active & (ilim_cnt_reg == ILIM_CYC - 20'h0_0001);
  wire ilim_event = ilim_hit & ~ilim_state_reg;
  wire hw_disable = ts_rise | ov_rise | sc_trip;
  wire force_off = ~running | soft_wr | thermal_shutdown_in | overvoltage_in | sc_trip;

  // Regulator state: register bit acts at once, pin control waits for the timer
  always_comb begin
    if (force_off) begin
      main_regulator_next = 1'b0;
    end else if (!en_bit) begin
      main_regulator_next = 1'b0;
    end else if (!pin_sel) begin
      main_regulator_next = 1'b1;
    end else if (tif.done) begin
      main_regulator_next = target_on_reg;
    end else begin
      main_regulator_next = main_regulator_reg;
    end
  end

  // Sequencer: hold, optional soft clear, one-cycle fuse load, run
  always_comb begin
    seq_next = seq_reg;
    if (in_hold) begin
      seq_next = SEQ_HOLD;
    end else begin
      unique case (seq_reg)
        SEQ_HOLD: seq_next = SEQ_LOAD;
        SEQ_SOFT: seq_next = SEQ_LOAD;
        SEQ_LOAD: seq_next = SEQ_RUN;
        SEQ_RUN: seq_next = soft_wr ? SEQ_SOFT : SEQ_RUN;
      endcase
    end
  end

  // Shutdown fault gets reported once the regulator comes back up
  wire restart_set = load_fuse |
                     (fault_pending_reg & esr_rise(main_regulator_reg, reg_on_prev_reg));

  // Flag updates
  always_comb begin
    top_flags_next[`ESR_TF_TWARN] = esr_flag(top_flags_reg[`ESR_TF_TWARN],
      esr_rise(thermal_warning_in, tw_prev_reg), top_clr[`ESR_TF_TWARN],
      thermal_warning_in);
    top_flags_next[`ESR_TF_TSD] = esr_flag(top_flags_reg[`ESR_TF_TSD], ts_rise,
      top_clr[`ESR_TF_TSD], thermal_shutdown_in);
    top_flags_next[`ESR_TF_OVP] = esr_flag(top_flags_reg[`ESR_TF_OVP], ov_rise,
      top_clr[`ESR_TF_OVP], overvoltage_in);
    top_flags_next[`ESR_TF_PIN] = esr_flag(top_flags_reg[`ESR_TF_PIN],
      gpio_in != gpio_prev_reg, top_clr[`ESR_TF_PIN], 1'b0);
    top_flags_next[`ESR_TF_CLK] = esr_flag(top_flags_reg[`ESR_TF_CLK],
      ext_clk_present != clk_prev_reg, top_clr[`ESR_TF_CLK], 1'b0);
    top_flags_next[`ESR_TF_MEAS] = esr_flag(top_flags_reg[`ESR_TF_MEAS], meas_done,
      top_clr[`ESR_TF_MEAS], 1'b0);
    top_flags_next[`ESR_TF_RESTART] = esr_flag(top_flags_reg[`ESR_TF_RESTART], restart_set,
      top_clr[`ESR_TF_RESTART], 1'b0);
    reg_flags_next[`ESR_RF_ILIM] = esr_flag(reg_flags_reg[`ESR_RF_ILIM], ilim_event,
      reg_clr[`ESR_RF_ILIM], ilim_state_reg);
    reg_flags_next[`ESR_RF_SC] = esr_flag(reg_flags_reg[`ESR_RF_SC], sc_trip,
      reg_clr[`ESR_RF_SC], 1'b0);
    reg_flags_next[`ESR_RF_PG] = esr_flag(reg_flags_reg[`ESR_RF_PG],
      esr_rise(power_good_in, pg_prev_reg), reg_clr[`ESR_RF_PG], 1'b0);
  end

  // Unmaskable flags bypass the mask by the maskable constants
  wire int_pend = |(top_flags_reg & ~(top_mask_reg[6:0] & `ESR_TOP_MASKABLE)) |
                  |(reg_flags_reg & ~(reg_mask_reg[2:0] & `ESR_REG_MASKABLE));
  wire reg_summary = |reg_flags_reg;

  // Read selection; unmapped offsets read zero
  wire [7:0] status_val = {1'b0, main_regulator_reg, power_good_in, ilim_state_reg,
                           ext_clk_present, overvoltage_in, thermal_shutdown_in,
                           thermal_warning_in};
  wire [7:0] rd_mux = (addr == `ESR_ADDR_CTRL) ? ctrl_reg :
                      (addr == `ESR_ADDR_DELAY) ? delay_reg :
                      (addr == `ESR_ADDR_CONFIG) ? config_reg :
                      (addr == `ESR_ADDR_TOP_FLAGS) ? {reg_summary, top_flags_reg} :
                      (addr == `ESR_ADDR_REG_FLAGS) ? {5'h00, reg_flags_reg} :
                      (addr == `ESR_ADDR_TOP_MASK) ? top_mask_reg :
                      (addr == `ESR_ADDR_REG_MASK) ? reg_mask_reg :
                      (addr == `ESR_ADDR_STATUS) ? status_val :
                      (addr == `ESR_ADDR_PIN_IN) ? {4'h0, gpio_in} : `ESR_BYTE_ZERO;

  // Host interface: only the power-on reset touches it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= `ESR_BYTE_ZERO;
    end else begin
      rdata_reg <= rd ? rd_mux : `ESR_BYTE_ZERO;
    end
  end

  // Software-visible configuration
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= `ESR_CTRL_RST;
      delay_reg <= `ESR_DELAY_RST;
      config_reg <= `ESR_CONFIG_RST;
      top_mask_reg <= `ESR_MASK_RST;
      reg_mask_reg <= `ESR_MASK_RST;
    end else if (clr_regs) begin
      ctrl_reg <= `ESR_CTRL_RST;
      delay_reg <= `ESR_DELAY_RST;
      config_reg <= `ESR_CONFIG_RST;
      top_mask_reg <= `ESR_MASK_RST;
      reg_mask_reg <= `ESR_MASK_RST;
    end else if (load_fuse) begin
      ctrl_reg <= fuse_ctrl;
      delay_reg <= fuse_delay;
      config_reg <= fuse_config;
    end else begin
      // A protection trip drops the enable bit so it stays off after recovery
      if (hw_disable) begin
        ctrl_reg <= ctrl_reg & ~(8'h01 << `ESR_CTRL_EN);
      end else if (wr_ctrl) begin
        ctrl_reg <= wdata;
      end
      if (wr_delay) begin
        delay_reg <= wdata;
      end
      if (wr_config) begin
        config_reg <= wdata;
      end
      if (wr_top_mask) begin
        top_mask_reg <= wdata;
      end
      if (wr_reg_mask) begin
        reg_mask_reg <= wdata;
      end
    end
  end

  // Flags, sequencer and regulator output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_reg <= SEQ_HOLD;
      top_flags_reg <= 7'h00;
      reg_flags_reg <= 3'h0;
      main_regulator_reg <= 1'b0;
      target_on_reg <= 1'b0;
      irq_n_reg <= 1'b1;
      gpio_force_low_reg <= 1'b0;
    end else begin
      seq_reg <= seq_next;
      top_flags_reg <= clr_regs ? 7'h00 : top_flags_next;
      reg_flags_reg <= clr_regs ? 3'h0 : reg_flags_next;
      main_regulator_reg <= main_regulator_next;
      if (tif.start) begin
        target_on_reg <= pin_rise;
      end
      irq_n_reg <= ~int_pend;
      gpio_force_low_reg <= thermal_shutdown_in | overvoltage_in |
                            top_flags_reg[`ESR_TF_TSD] | top_flags_reg[`ESR_TF_OVP];
    end
  end

  // Fault memory survives the register clear so it can be reported later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_pending_reg <= 1'b0;
    end else if (ts_rise | ov_rise) begin
      fault_pending_reg <= 1'b1;
    end else if (restart_set & ~load_fuse) begin
      fault_pending_reg <= 1'b0;
    end
  end

  // Debounce counters for short circuit and current limit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sc_cnt_reg <= 20'h0_0000;
      ilim_cnt_reg <= 20'h0_0000;
      ilim_state_reg <= 1'b0;
    end else begin
      sc_cnt_reg <= (main_regulator_reg & ~vout_above_sc & ~sc_trip) ?
                    sc_cnt_reg + 20'h0_0001 : 20'h0_0000;
      ilim_cnt_reg <= ~current_limit_active ? 20'h0_0000 :
                      ilim_hit ? ilim_cnt_reg : ilim_cnt_reg + 20'h0_0001;
      ilim_state_reg <= current_limit_active & (ilim_state_reg | ilim_hit);
    end
  end

  // Previous samples for edge and change detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_prev_reg <= 1'b0;
      tw_prev_reg <= 1'b0;
      ts_prev_reg <= 1'b0;
      ov_prev_reg <= 1'b0;
      pg_prev_reg <= 1'b0;
      clk_prev_reg <= 1'b0;
      reg_on_prev_reg <= 1'b0;
      gpio_prev_reg <= 4'h0;
    end else begin
      pin_prev_reg <= sel_pin;
      tw_prev_reg <= thermal_warning_in;
      ts_prev_reg <= thermal_shutdown_in;
      ov_prev_reg <= overvoltage_in;
      pg_prev_reg <= power_good_in;
      clk_prev_reg <= ext_clk_present;
      reg_on_prev_reg <= main_regulator_reg;
      gpio_prev_reg <= gpio_in;
    end
  end

  assign rdata = rdata_reg;
  assign main_regulator = main_regulator_reg;
  assign gpio_force_low = gpio_force_low_reg;
  assign interrupt_output_low_n = irq_n_reg;
endmodule

/* verif/esr_host_model.sv */
`timescale 1ns/1ps
`include "esr_consts.svh"
module esr_host_model
  import esr_pkg::*;
#(
  parameter int WAIT_CYC = 40
) (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  output logic [2:0] enable_inputs
);
  // Idle bus and pins low from time zero
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    enable_inputs = 3'h0;
  end
  // Address and data are inverted once released, so nothing stale looks valid
  task automatic wreg(input esr_byte_t a, input esr_byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rreg(input esr_byte_t a, output esr_byte_t d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(negedge clk);
    d = rdata;
  endtask
  // Control stays on the one pin; edge sensing forbids a swap
  task automatic pin1(input logic v);
    @(posedge clk);
    enable_inputs[1] <= v;
  endtask
  // Quiet time is shortened; the full span would dwarf the run
  task automatic por_wait();
    repeat (WAIT_CYC) @(posedge clk);
  endtask
  task automatic soft_reset();
    wreg(`ESR_ADDR_RESET, 8'h01);
    repeat (WAIT_CYC) @(posedge clk);
  endtask
endmodule

/* verif/esr_top_properties.sv */
`timescale 1ns/1ps
`include "esr_consts.svh"
module esr_top_checker
  import esr_pkg::*;
#(
  parameter logic [19:0] SC_CYC = 20'h0_0010
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic analog_supply_ok,
  input wire logic external_reset_input_n,
  input wire logic vout_above_sc,
  input wire logic thermal_shutdown_in,
  input wire logic overvoltage_in,
  input wire logic main_regulator,
  input wire logic gpio_force_low,
  input wire logic interrupt_output_low_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic good;
  logic [19:0] low_cnt_reg;
  logic [19:0] low_cnt_next;
  // Supply and reset pin both good
  assign good = analog_supply_ok && external_reset_input_n;
  // Length of a low-output spell while on; the short timeout must end it
  assign low_cnt_next = (main_regulator && !vout_above_sc) ? low_cnt_reg + 20'h0_0001 : 20'h0_0000;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt_reg <= 20'h0_0000;
    end else begin
      low_cnt_reg <= low_cnt_next;
    end
  end
  a_lockout_reg_off: assert property (!good |=> !main_regulator)
    else $error("regulator on during lockout");
  a_lockout_irq_idle: assert property (!good [*2] |=> interrupt_output_low_n)
    else $error("interrupt pending during lockout");
  a_shutdown_acted: assert property (
    thermal_shutdown_in |=> !main_regulator && gpio_force_low)
    else $error("thermal shutdown not acted on");
  a_overvolt_acted: assert property (
    overvoltage_in |=> !main_regulator && gpio_force_low)
    else $error("overvoltage not acted on");
  a_fault_irq_low: assert property (
    $rose(thermal_shutdown_in || overvoltage_in) && good |-> ##[1:3] !interrupt_output_low_n)
    else $error("fault did not pull interrupt");
  a_restart_irq_low: assert property (
    $fell(rst) ##0 good [*3] |-> ##[1:3] !interrupt_output_low_n)
    else $error("no restart interrupt after reset");
  a_short_timeout: assert property (low_cnt_reg < SC_CYC + 20'h0_0004)
    else $error("low output not tripped in time");
  a_soft_reg_off: assert property (
    wr && addr == `ESR_ADDR_RESET && wdata[`ESR_RESET_TRIG] |-> ##[1:3] !main_regulator)
    else $error("soft reset left regulator on");
  c_reg_on: cover property ($rose(main_regulator));
  c_short: cover property (low_cnt_reg == SC_CYC);
  c_soft: cover property (wr && addr == `ESR_ADDR_RESET);
endmodule
bind esr_top esr_top_checker #(.SC_CYC(SC_CYC)) u_checker (
  .clk(clk),
  .rst(rst),
  .addr(addr),
  .wdata(wdata),
  .wr(wr),
  .analog_supply_ok(analog_supply_ok),
  .external_reset_input_n(external_reset_input_n),
  .vout_above_sc(vout_above_sc),
  .thermal_shutdown_in(thermal_shutdown_in),
  .overvoltage_in(overvoltage_in),
  .main_regulator(main_regulator),
  .gpio_force_low(gpio_force_low),
  .interrupt_output_low_n(interrupt_output_low_n)
);

/* verif/testbench.sv */
`timescale 1ns/1ps
`include "esr_consts.svh"
module testbench
  import esr_pkg::*;
();
  localparam int FULL = 20;
  localparam int FRAC = 8;
  localparam int SCC = 16;
  localparam int ILC = 8;
  localparam logic [7:0] TOP = `ESR_ADDR_TOP_FLAGS;
  localparam logic [7:0] RGF = `ESR_ADDR_REG_FLAGS;
  localparam logic [7:0] RA [7] = '{`ESR_ADDR_CTRL, `ESR_ADDR_DELAY, `ESR_ADDR_CONFIG,
    `ESR_ADDR_TOP_MASK, `ESR_ADDR_REG_MASK, TOP, 8'h0F};
  localparam logic [7:0] RV [7] = '{8'h00, 8'h5A, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
  localparam logic [7:0] TX [6] = '{8'h01, 8'h08, 8'h10, 8'h20, 8'h80, 8'h80};
  localparam logic [7:0] GX [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h04};
  logic clk, rst, supply_ok, ext_rst_n, vsc, wr, rd, main_regulator, gpio_force_low, irq_n;
  logic [1:0] prot;
  logic [5:0] ev;
  logic [2:0] en_pins;
  logic [7:0] addr, wdata, rdata, fz;
  int failures, compares, cyc, n, stp;
  esr_top #(.STEP_FULL_CYC(20'(FULL)), .STEP_FRAC_CYC(20'(FRAC)), .SC_CYC(20'(SCC)),
    .ILIM_CYC(20'(ILC))) dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .analog_supply_ok(supply_ok), .external_reset_input_n(ext_rst_n),
    .fuse_ctrl(fz), .fuse_delay(8'h5A), .fuse_config(fz), .enable_inputs(en_pins),
    .vout_above_sc(vsc), .current_limit_active(ev[4]), .thermal_warning_in(ev[0]),
    .thermal_shutdown_in(prot[0]), .overvoltage_in(prot[1]), .power_good_in(ev[5]),
    .gpio_in({4{ev[1]}}), .ext_clk_present(ev[2]), .meas_done(ev[3]),
    .main_regulator(main_regulator), .gpio_force_low(gpio_force_low),
    .interrupt_output_low_n(irq_n));
  esr_host_model host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .enable_inputs(en_pins));
  // 250 MHz clock and a hang limit well past the expected run
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      $display("MISMATCH run length expected end seen hang");
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    esr_byte_t d;
    host.rreg(a, d);
    chk(nm, e, d);
  endtask
  // Timing is approximate by design, so a few cycles of slack
  task automatic win(input string nm, input int lo);
    compares++;
    if (n < lo || n > lo + 8) begin
      failures++;
      $display("MISMATCH %s expected %0d seen %0d", nm, lo, n);
    end
  endtask
  task automatic until_reg(input logic v);
    n = 0;
    while (main_regulator !== v && n < 3000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Test sequence
  initial begin
    {rst, supply_ok, ext_rst_n, vsc} = 4'hF;
    prot = 2'h0;
    ev = 6'h00;
    fz = 8'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    host.por_wait();
    for (int i = 0; i < 7; i++) rchk("reset value", RA[i], RV[i]);
    chk("irq at start", 8'h00, {7'h00, irq_n});
    host.wreg(TOP, 8'h40);
    repeat (2) @(negedge clk);
    chk("irq idle", 8'h01, {7'h00, irq_n});
    $display("test reset done");
    host.wreg(`ESR_ADDR_DELAY, 8'hFF);
    host.wreg(`ESR_ADDR_CTRL, 8'h01);
    until_reg(1'b1);
    win("bit on", 0);
    host.wreg(`ESR_ADDR_CTRL, 8'h00);
    until_reg(1'b0);
    win("bit off", 0);
    host.wreg(`ESR_ADDR_DELAY, 8'h12);
    host.wreg(`ESR_ADDR_CTRL, 8'h06);
    host.pin1(1'b1);
    repeat (80) @(negedge clk);
    chk("no enable bit", 8'h00, {7'h00, main_regulator});
    host.pin1(1'b0);
    host.wreg(`ESR_ADDR_CTRL, 8'h07);
    for (int s = 0; s < 4; s++) begin
      host.wreg(`ESR_ADDR_CONFIG, 8'(s));
      stp = (s[1] ? FRAC : FULL) * (s[0] ? 2 : 1);
      host.pin1(1'b1);
      until_reg(1'b1);
      win("on delay", 2 * stp);
      host.pin1(1'b0);
      until_reg(1'b0);
      win("off delay", stp);
    end
    host.pin1(1'b1);
    repeat (10) @(posedge clk);
    host.pin1(1'b0);
    repeat (80) @(negedge clk);
    chk("reversed edge", 8'h00, {7'h00, main_regulator});
    host.wreg(`ESR_ADDR_CTRL, 8'h00);
    $display("test enable control done");
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) ev <= 6'(1 << i);
      @(posedge clk) ev[3] <= 1'b0;
      repeat (12) @(posedge clk);
      rchk("top flags", TOP, TX[i]);
      rchk("reg flags", RGF, GX[i]);
      if (i == 1) rchk("pin levels", `ESR_ADDR_PIN_IN, 8'h0F);
      chk("irq low", 8'h00, {7'h00, irq_n});
      host.wreg(TOP, 8'hFF);
      host.wreg(RGF, 8'hFF);
      rchk("clear while live", TOP, (i == 0 || i == 4) ? TX[i] : 8'h00);
      @(posedge clk) ev <= 6'h00;
      repeat (12) @(posedge clk);
      host.wreg(TOP, 8'hFF);
      host.wreg(RGF, 8'hFF);
      repeat (2) @(negedge clk);
      chk("irq released", 8'h01, {7'h00, irq_n});
    end
    host.wreg(`ESR_ADDR_TOP_MASK, 8'h01);
    @(posedge clk) ev <= 6'h01;
    repeat (4) @(negedge clk);
    chk("masked irq", 8'h01, {7'h00, irq_n});
    rchk("masked flag", TOP, 8'h01);
    @(posedge clk) ev <= 6'h00;
    repeat (2) @(posedge clk);
    host.wreg(TOP, 8'hFF);
    host.wreg(`ESR_ADDR_TOP_MASK, 8'h00);
    $display("test flags done");
    for (int k = 0; k < 2; k++) begin
      host.wreg(`ESR_ADDR_CTRL, 8'h01);
      @(posedge clk) prot <= 2'(1 << k);
      repeat (3) @(negedge clk);
      chk("fault off", 8'h00, {7'h00, main_regulator});
      chk("pins low", 8'h01, {7'h00, gpio_force_low});
      host.wreg(TOP, 8'h7F);
      rchk("fault flag", TOP, 8'(2 << k));
      rchk("fault state", `ESR_ADDR_STATUS, 8'(2 << k));
      @(posedge clk) prot <= 2'h0;
      host.wreg(TOP, 8'h7F);
      rchk("fault cleared", TOP, 8'h00);
      rchk("enable dropped", `ESR_ADDR_CTRL, 8'h00);
      host.wreg(`ESR_ADDR_CTRL, 8'h01);
      repeat (6) @(negedge clk);
      rchk("fault reported", TOP, 8'h40);
      host.wreg(TOP, 8'h40);
    end
    @(posedge clk) vsc <= 1'b0;
    until_reg(1'b0);
    win("short trip", SCC);
    rchk("short flag", RGF, 8'h02);
    @(posedge clk) vsc <= 1'b1;
    host.wreg(RGF, 8'h02);
    rchk("short cleared", RGF, 8'h00);
    $display("test protection done");
    host.wreg(`ESR_ADDR_CTRL, 8'h01);
    host.wreg(`ESR_ADDR_DELAY, 8'h33);
    host.soft_reset();
    chk("soft off", 8'h00, {7'h00, main_regulator});
    rchk("trigger clear", `ESR_ADDR_RESET, 8'h00);
    rchk("fuse reload", `ESR_ADDR_DELAY, 8'h5A);
    rchk("ctrl default", `ESR_ADDR_CTRL, 8'h00);
    rchk("restart flag", TOP, 8'h40);
    host.wreg(TOP, 8'h40);
    for (int k = 0; k < 2; k++) begin
      host.wreg(`ESR_ADDR_CTRL, 8'h01);
      @(posedge clk) {ext_rst_n, supply_ok} <= k ? 2'b10 : 2'b01;
      fz <= 8'(k);
      repeat (4) @(negedge clk);
      chk("lockout off", 8'h00, {7'h00, main_regulator});
      rchk("lockout default", `ESR_ADDR_DELAY, 8'h00);
      @(posedge clk) {ext_rst_n, supply_ok} <= 2'b11;
      host.por_wait();
      rchk("fuse reload", `ESR_ADDR_DELAY, 8'h5A);
      chk("fuse start", 8'(k), {7'h00, main_regulator});
      rchk("fuse config", `ESR_ADDR_CONFIG, 8'(k));
      rchk("restart flag", TOP, 8'h40);
      host.wreg(TOP, 8'h40);
    end
    $display("test resets done");
    wrap_up();
  end
endmodule
